/* File: rtl/scc_top.sv */
// strap-selected clock synthesizer control: strap capture, rate select, down-spread sweep
// assumes straps arrive as sensed level codes synchronous to i_clk, and an AXI4-Lite master
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.

module scc_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_digital_supply_ok,
  input  wire logic [1:0]  i_cpu_freq_strap_hi,
  input  wire logic [1:0]  i_cpu_freq_strap_lo,
  input  wire logic [1:0]  i_spread_strap_hi,
  input  wire logic [1:0]  i_spread_strap_lo,
  input  wire logic [1:0]  i_usb_pin,
  output logic             o_usb_pin,
  output logic             o_usb_pin_oe,
  output logic [17:0]      o_cpu_freq_khz,
  output logic             o_spread_spectrum_mod,
  output logic             o_straps_done,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int unsigned FW = scc_pkg::FREQ_W;
  localparam int unsigned DW = scc_pkg::DEPTH_W;
  localparam int unsigned TW = scc_pkg::TRI_W;

  // tri-level pin resolution
  function automatic scc_pkg::scc_tri_t tri_res(input logic [1:0] lvl);
    scc_pkg::scc_tri_t t;
    t = scc_pkg::TRI_M;
    if (lvl == scc_pkg::LVL_GND) begin
      t = scc_pkg::TRI_0;
    end else if (lvl == scc_pkg::LVL_VDD) begin
      t = scc_pkg::TRI_1;
    end
    return t;
  endfunction

  // table index of a resolved tri-level value: 0, mid, 1 -> 0, 1, 2
  function automatic logic [3:0] tri_idx(input scc_pkg::scc_tri_t t);
    logic [3:0] i;
    i = 4'h1;
    if (t == scc_pkg::TRI_0) begin
      i = 4'h0;
    end else if (t == scc_pkg::TRI_1) begin
      i = 4'h2;
    end
    return i;
  endfunction

  scc_pkg::scc_state_t state_ff;
  scc_pkg::scc_state_t nxt_state;
  logic [scc_pkg::SETTLE_W-1:0] settle_ff;
  logic [scc_pkg::SETTLE_W-1:0] nxt_settle;

  scc_pkg::scc_tri_t fs_hi_ff;
  scc_pkg::scc_tri_t fs_lo_ff;
  scc_pkg::scc_tri_t usb_sel_ff;
  logic [1:0]        ss_ff;

  logic [2:0]        ctrl_ff;
  logic [FW-1:0]     cpu_khz_ff;
  logic              ss_act_ff;
  logic              oe_ff;
  logic              done_ff;

  logic [scc_pkg::STEP_W-1:0] step_cnt_ff;
  logic [TW-1:0]              tri_ff;
  logic                       tri_up_ff;

  // capture sequence: a low supply-good level sends it back to wait; control and strap registers keep their values
  wire settle_end = (settle_ff == scc_pkg::SETTLE_W'(scc_pkg::SETTLE_CYCLES - 1));

  always_comb begin
    nxt_state  = state_ff;
    nxt_settle = '0;
    case (state_ff)
      scc_pkg::ST_WAIT: begin
        if (i_digital_supply_ok) begin
          nxt_state = scc_pkg::ST_SETTLE;
        end
      end
      scc_pkg::ST_SETTLE: begin
        nxt_settle = settle_ff + 1'b1;
        if (settle_end) begin
          nxt_state = scc_pkg::ST_LATCH;
        end
      end
      scc_pkg::ST_LATCH: begin
        nxt_state = scc_pkg::ST_RUN;
      end
      scc_pkg::ST_RUN: begin
        nxt_state = scc_pkg::ST_RUN;
      end
      default: begin
        nxt_state = scc_pkg::ST_WAIT;
      end
    endcase
    if (!i_digital_supply_ok) begin
      nxt_state = scc_pkg::ST_WAIT;            // supply loss is a new power-up
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff  <= scc_pkg::ST_WAIT;
      settle_ff <= '0;
    end else begin
      state_ff  <= nxt_state;
      settle_ff <= nxt_settle;
    end
  end

  // straps latched once, in the latch state only; held until next power-up
  wire latch_now = (state_ff == scc_pkg::ST_LATCH);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fs_hi_ff   <= scc_pkg::TRI_M;
      fs_lo_ff   <= scc_pkg::TRI_M;
      usb_sel_ff <= scc_pkg::TRI_M;
      ss_ff      <= 2'h3;
    end else if (latch_now) begin
      fs_hi_ff   <= tri_res(i_cpu_freq_strap_hi);
      fs_lo_ff   <= tri_res(i_cpu_freq_strap_lo);
      usb_sel_ff <= tri_res(i_usb_pin);
      ss_ff[1]   <= (i_spread_strap_hi != scc_pkg::LVL_GND);
      ss_ff[0]   <= (i_spread_strap_lo != scc_pkg::LVL_GND);
    end
  end

  // processor rate select from the crystal-derived table
  wire [3:0]    cpu_idx = 4'(tri_idx(fs_hi_ff) * 4'h3) + tri_idx(fs_lo_ff);
  wire [FW-1:0] cpu_nom = scc_pkg::CPU_KHZ[cpu_idx];

  // spread depth from the two spread straps
  wire [DW-1:0] depth_sel = (ss_ff == 2'h1) ? scc_pkg::DEPTH_050 :
                            (ss_ff == 2'h2) ? scc_pkg::DEPTH_100 :
                            (ss_ff == 2'h3) ? scc_pkg::DEPTH_125 :
                            scc_pkg::DEPTH_OFF;
  wire          running   = (state_ff == scc_pkg::ST_RUN);
  wire          ss_on     = running && (ss_ff != 2'h0) && !ctrl_ff[scc_pkg::CTRL_SS_OFF];

  // second clock step word, never modulated
  wire [scc_pkg::NCO_W-1:0] usb_step =
    (usb_sel_ff == scc_pkg::TRI_0) ? scc_pkg::NCO_STEP_0 :
    (usb_sel_ff == scc_pkg::TRI_1) ? scc_pkg::NCO_STEP_1 :
    scc_pkg::NCO_STEP_M;
  wire [FW-1:0] usb_khz =
    (usb_sel_ff == scc_pkg::TRI_0) ? scc_pkg::USB_KHZ_0 :
    (usb_sel_ff == scc_pkg::TRI_1) ? scc_pkg::USB_KHZ_1 :
    scc_pkg::USB_KHZ_M;

  // sweep step enable from a divider
  wire step_en = (step_cnt_ff == scc_pkg::STEP_W'(scc_pkg::STEP_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      step_cnt_ff <= '0;
    end else if (!ss_on || step_en) begin
      step_cnt_ff <= '0;
    end else begin
      step_cnt_ff <= step_cnt_ff + 1'b1;
    end
  end

  // triangle sweep 0..TRI_STEPS..0, one period near the sweep rate
  wire tri_top = (tri_ff == TW'(scc_pkg::TRI_STEPS - 1));
  wire tri_bot = (tri_ff == TW'(1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tri_ff    <= '0;
      tri_up_ff <= 1'b1;
    end else if (!ss_on) begin
      tri_ff    <= '0;
      tri_up_ff <= 1'b1;
    end else if (step_en) begin
      tri_ff    <= tri_up_ff ? tri_ff + 1'b1 : tri_ff - 1'b1;
      if (tri_up_ff && tri_top) begin
        tri_up_ff <= 1'b0;
      end else if (!tri_up_ff && tri_bot) begin
        tri_up_ff <= 1'b1;
      end
    end
  end

  // down-spread offset: nominal * depth * tri / (scale * steps)
  wire [39:0] prod    = 40'(cpu_nom) * 40'(depth_sel) * 40'(tri_ff);
  wire [39:0] off_w   = prod / 40'(scc_pkg::DEPTH_SCALE * scc_pkg::TRI_STEPS);
  wire [FW-1:0] cpu_mod = ss_on ? cpu_nom - off_w[FW-1:0] : cpu_nom;

  // output rate, gated off until capture and when software stops it
  wire [FW-1:0] nxt_cpu_khz = (running && ctrl_ff[scc_pkg::CTRL_CPU_EN]) ? cpu_mod : '0;
  wire          usb_run     = running && ctrl_ff[scc_pkg::CTRL_USB_EN];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cpu_khz_ff <= '0;
      ss_act_ff  <= 1'b0;
      oe_ff      <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      cpu_khz_ff <= nxt_cpu_khz;
      ss_act_ff  <= ss_on;
      oe_ff      <= usb_run;
      done_ff    <= running;
    end
  end

  // second clock synthesizer
  scc_nco #(
    .W (scc_pkg::NCO_W)
  ) u_nco (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_en    (usb_run),
    .i_step  (usb_step),
    .o_clk   (o_usb_pin)
  );

  assign o_usb_pin_oe          = oe_ff;
  assign o_cpu_freq_khz        = cpu_khz_ff;
  assign o_spread_spectrum_mod = ss_act_ff;
  assign o_straps_done         = done_ff;

  // AXI4-Lite write path: address and data taken in either order
  logic        aw_full_ff;
  logic        w_full_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        aw_rdy_ff;
  logic        w_rdy_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;

  wire aw_hs     = s_axi_awvalid && aw_rdy_ff;
  wire w_hs      = s_axi_wvalid && w_rdy_ff;
  wire aw_have   = aw_full_ff || aw_hs;
  wire w_have    = w_full_ff || w_hs;
  wire wr_go     = aw_have && w_have && !bvalid_ff;
  wire [7:0] wa  = aw_full_ff ? aw_addr_ff : s_axi_awaddr;
  wire [31:0] wd = w_full_ff ? w_data_ff : s_axi_wdata;
  wire [3:0] ws  = w_full_ff ? w_strb_ff : s_axi_wstrb;
  wire wr_known  = (wa == scc_pkg::REG_CTRL) || (wa == scc_pkg::REG_STATUS) ||
                   (wa == scc_pkg::REG_CPU_KHZ) || (wa == scc_pkg::REG_USB_KHZ) ||
                   (wa == scc_pkg::REG_SPREAD);
  wire wr_ctrl   = wr_go && (wa == scc_pkg::REG_CTRL) && ws[0];
  wire nxt_aw_full = aw_have && !wr_go;
  wire nxt_w_full  = w_have && !wr_go;
  wire nxt_bvalid  = wr_go || (bvalid_ff && !s_axi_bready);

  // write channel state
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
      aw_rdy_ff  <= 1'b0;
      w_rdy_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= scc_pkg::RESP_OKAY;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff  <= nxt_w_full;
      if (aw_hs) begin
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      aw_rdy_ff <= !nxt_aw_full && !nxt_bvalid;
      w_rdy_ff  <= !nxt_w_full && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (wr_go) begin
        bresp_ff <= wr_known ? scc_pkg::RESP_OKAY : scc_pkg::RESP_DECERR;
      end
    end
  end

  // control register, low byte lane only
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_ff <= scc_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= wd[2:0];
    end
  end

  assign s_axi_awready = aw_rdy_ff;
  assign s_axi_wready  = w_rdy_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // AXI4-Lite read path
  logic        ar_rdy_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  wire ar_hs = s_axi_arvalid && ar_rdy_ff;
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] stat_word = {21'h0, done_ff, ss_ff, 2'(tri_idx(usb_sel_ff)),
                           2'(tri_idx(fs_lo_ff)), 2'(tri_idx(fs_hi_ff)), 2'(state_ff)};
  wire rd_ctrl = (ra == scc_pkg::REG_CTRL);
  wire rd_stat = (ra == scc_pkg::REG_STATUS);
  wire rd_cpu  = (ra == scc_pkg::REG_CPU_KHZ);
  wire rd_usb  = (ra == scc_pkg::REG_USB_KHZ);
  wire rd_ss   = (ra == scc_pkg::REG_SPREAD);
  wire rd_known = rd_ctrl || rd_stat || rd_cpu || rd_usb || rd_ss;
  wire [31:0] rd_word = rd_ctrl ? {29'h0, ctrl_ff} :
                        rd_stat ? stat_word :
                        rd_cpu  ? {14'h0, cpu_khz_ff} :
                        rd_usb  ? (done_ff ? {14'h0, usb_khz} : 32'h0) :
                        rd_ss   ? {24'h0, ss_act_ff, depth_sel} :
                        32'h0;
  wire nxt_rvalid = ar_hs || (rvalid_ff && !s_axi_rready);

  // read channel state
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ar_rdy_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= scc_pkg::RESP_OKAY;
    end else begin
      ar_rdy_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_known ? scc_pkg::RESP_OKAY : scc_pkg::RESP_DECERR;
      end
    end
  end

  assign s_axi_arready = ar_rdy_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

endmodule

/* File: rtl/scc_pkg.sv */
// constants and types shared by the strap-selected clock control block
// assumes a single 100 MHz system clock and straps sensed as three-state level codes
package scc_pkg;

  // system clock rate
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_KHZ       = 1000000 / CLK_PERIOD_NS;

  // crystal reference, not used by any rate here; the second clock steps are worked from CLK_KHZ
  localparam int unsigned XTAL_HZ = 14318180;

  // sensed pin level codes: ground, open, supply
  localparam logic [1:0] LVL_GND  = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_VDD  = 2'h2;

  // resolved tri-level strap value
  typedef enum logic [1:0] {
    TRI_0 = 2'b00,
    TRI_M = 2'b01,
    TRI_1 = 2'b10
  } scc_tri_t;

  // processor clock table in kHz, index = upper strap * 3 + lower strap
  localparam int unsigned FREQ_W = 18;
  localparam logic [FREQ_W-1:0] CPU_KHZ [9] = '{
    18'h0c350, 18'h1046e, 18'h124f8,
    18'h13880, 18'h14582, 18'h15b30,
    18'h186a0, 18'h1e848, 18'h1ff54
  };

  // second clock rates in kHz: 48 MHz, 30 MHz, 12 MHz
  localparam logic [FREQ_W-1:0] USB_KHZ_0 = 18'h0bb80;
  localparam logic [FREQ_W-1:0] USB_KHZ_M = 18'h07530;
  localparam logic [FREQ_W-1:0] USB_KHZ_1 = 18'h02ee0;

  // phase step for the second clock synthesizer: khz * 2^32 / clock khz
  localparam int unsigned NCO_W = 32;
  localparam logic [63:0] NCO_NUM_0 = 64'(USB_KHZ_0) << NCO_W;
  localparam logic [63:0] NCO_NUM_M = 64'(USB_KHZ_M) << NCO_W;
  localparam logic [63:0] NCO_NUM_1 = 64'(USB_KHZ_1) << NCO_W;
  localparam logic [NCO_W-1:0] NCO_STEP_0 = NCO_W'(NCO_NUM_0 / 64'(CLK_KHZ));
  localparam logic [NCO_W-1:0] NCO_STEP_M = NCO_W'(NCO_NUM_M / 64'(CLK_KHZ));
  localparam logic [NCO_W-1:0] NCO_STEP_1 = NCO_W'(NCO_NUM_1 / 64'(CLK_KHZ));

  // down-spread depth in hundredths of a percent
  localparam int unsigned DEPTH_W = 7;
  localparam logic [DEPTH_W-1:0] DEPTH_OFF = 7'h00;
  localparam logic [DEPTH_W-1:0] DEPTH_050 = 7'h32;
  localparam logic [DEPTH_W-1:0] DEPTH_100 = 7'h64;
  localparam logic [DEPTH_W-1:0] DEPTH_125 = 7'h7d;
  localparam int unsigned DEPTH_SCALE = 10000;

  // modulation sweep: triangle of TRI_STEPS levels up and down per period
  localparam int unsigned SWEEP_KHZ     = 28;
  localparam int unsigned SWEEP_CYCLES  = CLK_KHZ / SWEEP_KHZ;
  localparam int unsigned TRI_STEPS     = 64;
  localparam int unsigned TRI_W         = 7;
  localparam int unsigned STEP_CYCLES   = SWEEP_CYCLES / (2 * TRI_STEPS);
  localparam int unsigned STEP_W        = 5;

  // strap settle time after the supply is good, rounded up to cycles
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W      = 8;

  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_CPU_KHZ  = 8'h08;
  localparam logic [7:0] REG_USB_KHZ  = 8'h0c;
  localparam logic [7:0] REG_SPREAD   = 8'h10;

  // control fields and reset value
  localparam int unsigned CTRL_CPU_EN  = 0;
  localparam int unsigned CTRL_USB_EN  = 1;
  localparam int unsigned CTRL_SS_OFF  = 2;
  localparam logic [2:0]  CTRL_RST     = 3'h3;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // power-up strap capture sequence
  typedef enum logic [1:0] {
    ST_WAIT   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_LATCH  = 2'b10,
    ST_RUN    = 2'b11
  } scc_state_t;

endpackage

/* File: rtl/scc_nco.sv */
// phase-accumulator clock synthesizer for the second clock output
// assumes the step word is static while enabled; output is a registered square wave
module scc_nco #(
  parameter int unsigned W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_step,
  output logic              o_clk
);

  logic [W-1:0] acc_ff;
  logic         out_ff;

  // accumulate phase while enabled, park at zero otherwise
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_ff <= '0;
      out_ff <= 1'b0;
    end else if (i_en) begin
      acc_ff <= acc_ff + i_step;
      out_ff <= acc_ff[W-1];
    end else begin
      acc_ff <= '0;
      out_ff <= 1'b0;
    end
  end

  assign o_clk = out_ff;

endmodule

/* File: test/scc_board.sv */
// board around the clock control: strap tie choices in, sensed level codes out
// assumes the bench picks each tie; the shared pin reads back the device driver once enabled
module scc_board (
  input  wire logic       i_usb_oe,
  input  wire logic       i_usb_drv,
  input  wire logic [1:0] i_fs_hi_tie,
  input  wire logic [1:0] i_fs_lo_tie,
  input  wire logic [1:0] i_usb_tie,
  input  wire logic [1:0] i_ss_tie,
  output logic [1:0]      o_fs_hi,
  output logic [1:0]      o_fs_lo,
  output logic [1:0]      o_ss_hi,
  output logic [1:0]      o_ss_lo,
  output logic [1:0]      o_usb
);
  // tri-level ties: ground 0, open 1, supply 2
  assign o_fs_hi = i_fs_hi_tie;
  assign o_fs_lo = i_fs_lo_tie;
  // two-level ties: a clear bit grounds the strap, a set bit leaves it open
  assign o_ss_hi = i_ss_tie[1] ? 2'h1 : 2'h0;
  assign o_ss_lo = i_ss_tie[0] ? 2'h1 : 2'h0;
  // shared pin: resistor tie until the device driver takes over
  assign o_usb = i_usb_oe ? {i_usb_drv, 1'b0} : i_usb_tie;
endmodule

/* File: test/scc_top_chk.sv */
// port checker for the strap-selected clock control
// assumes one clock domain and bind onto scc_top
module scc_top_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_digital_supply_ok,
  input wire logic        o_usb_pin,
  input wire logic        o_usb_pin_oe,
  input wire logic [17:0] o_cpu_freq_khz,
  input wire logic        o_spread_spectrum_mod,
  input wire logic        o_straps_done,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // edges seen with the supply good, saturating
  logic [7:0] sup_cnt_ff;
  logic [7:0] nxt_sup_cnt;
  assign nxt_sup_cnt = !i_digital_supply_ok ? 8'h00 : (sup_cnt_ff == 8'hff) ? sup_cnt_ff : sup_cnt_ff + 8'h01;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) sup_cnt_ff <= 8'h00;
    else sup_cnt_ff <= nxt_sup_cnt;
  end

  // running with a fixed rate
  sequence steady_run_s;
    o_straps_done && !o_spread_spectrum_mod && o_cpu_freq_khz != 18'h0;
  endsequence

  oe_after_done_a: assert property (o_usb_pin_oe |-> o_straps_done)
    else $error("shared pin driven before capture");
  quiet_before_a: assert property (sup_cnt_ff >= 8'h01 && sup_cnt_ff <= 8'h63 |->
    o_cpu_freq_khz == 18'h0 && !o_usb_pin_oe && !o_usb_pin && !o_straps_done) else $error("output active in settle");
  capture_time_a: assert property ($rose(o_straps_done) |-> sup_cnt_ff >= 8'h65 && sup_cnt_ff <= 8'h69)
    else $error("capture finished at wrong time");
  capture_bound_a: assert property (sup_cnt_ff == 8'h6e |-> o_straps_done)
    else $error("capture never finished");
  supply_drop_a: assert property (!i_digital_supply_ok ##1 !i_digital_supply_ok |=> !o_straps_done && !o_usb_pin_oe)
    else $error("run kept through supply loss");
  steady_rate_a: assert property (steady_run_s ##1 steady_run_s |-> $stable(o_cpu_freq_khz))
    else $error("rate moved without spread");
  sweep_moves_a: assert property (o_spread_spectrum_mod |-> ##[0:80] (!$stable(o_cpu_freq_khz) || !o_spread_spectrum_mod))
    else $error("spread rate not sweeping");
  mod_in_run_a: assert property (o_spread_spectrum_mod |-> o_straps_done)
    else $error("spread active before capture");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule

bind scc_top scc_top_chk u_scc_top_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_digital_supply_ok(i_digital_supply_ok),
  .o_usb_pin(o_usb_pin), .o_usb_pin_oe(o_usb_pin_oe), .o_cpu_freq_khz(o_cpu_freq_khz),
  .o_spread_spectrum_mod(o_spread_spectrum_mod), .o_straps_done(o_straps_done), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

/* File: test/scc_top_tb.sv */
// self-checking bench for the strap-selected clock control
// assumes scc_top, the board model and the bound checker are compiled first
module scc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        supply_ok = 1'b0;
  logic [1:0]  fs_hi_tie = 2'h1, fs_lo_tie = 2'h1, usb_tie = 2'h1, ss_tie = 2'h3;
  logic [1:0]  fs_hi, fs_lo, ss_hi, ss_lo, usb_in, bresp, rresp, resp;
  logic        usb_out, usb_oe, ss_mod, done, awready, wready, bvalid, arready, rvalid;
  logic [17:0] cpu_khz;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  int          bad_count = 0;
  int          total_checks = 0;
  localparam logic [31:0] CPU_EXP [9] = '{32'h0000c350, 32'h0001046e, 32'h000124f8, 32'h00013880,
    32'h00014582, 32'h00015b30, 32'h000186a0, 32'h0001e848, 32'h0001ff54};
  localparam logic [31:0] USB_EXP [3] = '{32'h0000bb80, 32'h00007530, 32'h00002ee0};
  localparam logic [6:0]  DEPTH_EXP [4] = '{7'h00, 7'h32, 7'h64, 7'h7d};
  localparam int          RISES [3] = '{1680, 1050, 420};

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  scc_board u_scc_board (.i_usb_oe(usb_oe), .i_usb_drv(usb_out), .i_fs_hi_tie(fs_hi_tie), .i_fs_lo_tie(fs_lo_tie),
    .i_usb_tie(usb_tie), .i_ss_tie(ss_tie), .o_fs_hi(fs_hi), .o_fs_lo(fs_lo), .o_ss_hi(ss_hi), .o_ss_lo(ss_lo),
    .o_usb(usb_in));
  scc_top u_scc_top (.i_clk(clk), .i_rst_b(rst_b), .i_digital_supply_ok(supply_ok), .i_cpu_freq_strap_hi(fs_hi),
    .i_cpu_freq_strap_lo(fs_lo), .i_spread_strap_hi(ss_hi), .i_spread_strap_lo(ss_lo), .i_usb_pin(usb_in),
    .o_usb_pin(usb_out), .o_usb_pin_oe(usb_oe), .o_cpu_freq_khz(cpu_khz), .o_spread_spectrum_mod(ss_mod),
    .o_straps_done(done), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // write: both channels offered together, response accepted a cycle late
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    repeat (50) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
      if (bvalid) bready <= 1'b1;
    end
    check(32'h0, 32'h1, "write stalled");
    end_of_test();
  endtask

  // read: answer accepted a cycle late so it must stand
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    repeat (50) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
      if (rvalid) rready <= 1'b1;
    end
    check(32'h0, 32'h1, "read stalled");
    end_of_test();
  endtask

  // registers before any capture: reset values, read-only and unmapped places
  task automatic sc_bus();
    check(32'(usb_oe), 32'h0, "pin driven before capture");
    axi_read(8'h00, rd, resp);
    check(rd, 32'h3, "ctrl reset");
    axi_read(8'h14, rd, resp);
    check({rd[29:0], resp}, 32'h3, "unmapped read");
    axi_write(8'h18, 32'h0, resp);
    check(32'(resp), 32'h3, "unmapped write");
    axi_write(8'h04, 32'hffffffff, resp);
    check(32'(resp), 32'h0, "read-only write");
    axi_read(8'h04, rd, resp);
    check(rd, 32'h354, "status before capture");
    axi_write(8'h00, 32'h7, resp);
    axi_read(8'h00, rd, resp);
    check(rd, 32'h7, "ctrl write");
  endtask

  // one power-up with strap set i, rate checks, then spread sweep with the second clock counted
  task automatic sc_select(input int i);
    int rises;
    int lo;
    int hi;
    int nom;
    logic prev;
    nom = int'(CPU_EXP[i]);
    @(posedge clk);
    fs_hi_tie <= 2'(i / 3);
    fs_lo_tie <= 2'(i % 3);
    usb_tie <= 2'(i % 3);
    ss_tie <= 2'(i % 4);
    supply_ok <= 1'b0;
    repeat (4) @(posedge clk);
    supply_ok <= 1'b1;
    for (int n = 0; n < 200 && done !== 1'b1; n++) @(posedge clk);
    if (done !== 1'b1) begin
      check(32'h0, 32'h1, "no capture");
      end_of_test();
    end
    repeat (2) @(posedge clk);
    check(32'(cpu_khz), CPU_EXP[i], "cpu rate");
    axi_read(8'h08, rd, resp);
    check(rd, CPU_EXP[i], "cpu rate reg");
    axi_read(8'h0c, rd, resp);
    check(rd, USB_EXP[i % 3], "second rate reg");
    check(32'(usb_oe), 32'h1, "pin driven after capture");
    axi_write(8'h00, 32'h3, resp);
    repeat (4) @(posedge clk);
    axi_read(8'h10, rd, resp);
    check(rd, {24'h0, (i % 4) != 0, DEPTH_EXP[i % 4]}, "spread setting");
    check(32'(ss_mod), 32'((i % 4) != 0), "spread flag");
    lo = nom;
    hi = 0;
    rises = 0;
    prev = usb_out;
    repeat (3500) begin
      @(posedge clk);
      if (int'(cpu_khz) < lo) lo = int'(cpu_khz);
      if (int'(cpu_khz) > hi) hi = int'(cpu_khz);
      if (usb_out && !prev) rises++;
      prev = usb_out;
    end
    check(32'(hi), 32'(nom), "sweep top");
    check(32'(lo), 32'(nom - nom * int'(DEPTH_EXP[i % 4]) * 64 / 640000), "sweep bottom");
    check(32'(rises >= RISES[i % 3] - 2 && rises <= RISES[i % 3] + 2), 32'h1, "second clock edges");
    axi_write(8'h00, 32'h7, resp);
  endtask

  // straps moved after capture are ignored; enables take the outputs down
  task automatic sc_frozen();
    @(posedge clk);
    fs_hi_tie <= 2'h0;
    fs_lo_tie <= 2'h0;
    usb_tie <= 2'h0;
    ss_tie <= 2'h3;
    repeat (50) @(posedge clk);
    check(32'(cpu_khz), CPU_EXP[8], "rate after strap change");
    axi_read(8'h04, rd, resp);
    check(rd, 32'h4ab, "status after strap change");
    axi_write(8'h00, 32'h4, resp);
    repeat (4) @(posedge clk);
    check({30'h0, usb_oe, |cpu_khz}, 32'h0, "outputs disabled");
    axi_write(8'h00, 32'h7, resp);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    sc_bus();
    for (int i = 0; i < 9; i++) sc_select(i);
    sc_frozen();
    end_of_test();
  end
endmodule
